// *** hw/pmcs_sync.sv ***
// Purpose: Three-stage synchroniser bank for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   A change counts once stages two and three agree
`default_nettype none
module pmcs_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output var  logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] out_d;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_comb begin
				out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : syncOut[i];
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			syncOut <= '0;
		end else begin
			s1_q    <= asyncIn;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			syncOut <= out_d;
		end
	end
endmodule
`default_nettype wire

// *** hw/pmcs_top.sv ***
// Purpose: Power mode and clock source select with AHB-Lite registers
// Assumes: Source running flags and wake pin arrive asynchronously
// Notes:   Clock gates are select levels, not glitch-free muxes
// Contract
// [RL1] Oscillator control bit 7 selects whether the CPU is clocked when managed. Code stops the CPU outside Run; bit 7 set keeps peripherals clocked.
// [RL2] Oscillator control bits 1:0 choose primary, secondary or internal source.
// [RL3] Primary source kind comes from three-bit configuration field, not select bits.
// [RL4] New select value switches immediately if source runs, after transition delay.
// [RL5] Idle or Sleep entered only on sleep command; gate bit decides which.
// [RL6] Sleep runs no clock; Run and Idle use the selected source.
// [RL7] Target mode set from bits configured before sleep; sleep alone then suffices.
// [RL8] Port A bit zero slow falling voltage raises interrupt-on-change wake.
// [RL9] Gate set gives Idle; clear gives Sleep, or Deep Sleep if enabled.
// [RL10] Request for a stopped source keeps current clock until it runs.
`include "pmcs_consts.svh"
`default_nettype none
module pmcs_top #(
	parameter int SWITCH_NS = `PMCS_SWITCH_NS
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	input  wire logic [2:0]  srcRunning,
	input  wire logic        portABitZero,
	output var  logic        cpuClkEn,
	output var  logic        periphClkEn,
	output var  logic [1:0]  activeSource,
	output var  logic [2:0]  primaryKind,
	output var  logic [1:0]  powerMode,
	output var  logic        ulpWakeIrq
);
	localparam int SWITCH_CYC_RAW = (SWITCH_NS * `PMCS_CLK_MHZ + 999) / 1000;
	localparam int SWITCH_CYC     = (SWITCH_CYC_RAW < 1) ? 1 : SWITCH_CYC_RAW;

	// Synchronised pins: source running flags and wake pin
	logic [3:0] pinSync;
	pmcs_sync #(
		.WIDTH(4)
	) u_sync (
		.clk    (clk),
		.rst_n  (rst_n),
		.asyncIn({portABitZero, srcRunning}),
		.syncOut(pinSync)
	);
	logic [2:0] runSync;
	logic       wakePin;
	assign runSync = pinSync[2:0];
	assign wakePin = pinSync[3];

	function automatic logic srcIsRunning(input logic [1:0] sel, input logic [2:0] run);
		logic r;
		r = 1'b0;
		case (sel)
			2'h0:    r = run[0];
			2'h1:    r = run[1];
			2'h2:    r = run[2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Bus address phase capture
	logic        apValid_q, apValid_d;
	logic        apWrite_q, apWrite_d;
	logic [11:0] apAddr_q,  apAddr_d;
	logic [31:0] hrdata_d;

	// Registers
	logic [7:0]  oscCtl_q,  oscCtl_d;
	logic [2:0]  priCfg_q,  priCfg_d;
	logic        ulpEn_q,   ulpEn_d;
	logic        ulpFlag_q, ulpFlag_d;
	logic        sleepCmd;
	logic        wakeCmd;

	always_comb begin
		apValid_d = hsel && hready && htrans[1];
		apWrite_d = hwrite;
		apAddr_d  = haddr;
		if (!(hsel && hready)) begin
			apWrite_d = apWrite_q;
			apAddr_d  = apAddr_q;
		end
	end

	logic wrOsc, wrCfg, wrCmd, wrWake;
	always_comb begin
		wrOsc  = apValid_q && apWrite_q && (apAddr_q == `PMCS_OFF_OSCCTL);
		wrCfg  = apValid_q && apWrite_q && (apAddr_q == `PMCS_OFF_CONFIG);
		wrCmd  = apValid_q && apWrite_q && (apAddr_q == `PMCS_OFF_COMMAND);
		wrWake = apValid_q && apWrite_q && (apAddr_q == `PMCS_OFF_WAKECTL);
		sleepCmd = wrCmd && hwdata[`PMCS_BIT_SLEEP];
		wakeCmd  = wrCmd && hwdata[`PMCS_BIT_WAKE];
	end

	// Wake pin falling edge detection on the synchronised level
	logic wakePinPrev_q, wakePinPrev_d;
	logic ulpEvent;
	always_comb begin
		wakePinPrev_d = wakePin;
		ulpEvent      = ulpEn_q && wakePinPrev_q && !wakePin; // RL8
	end

	always_comb begin
		oscCtl_d  = oscCtl_q;
		priCfg_d  = priCfg_q;
		ulpEn_d   = ulpEn_q;
		ulpFlag_d = ulpFlag_q;
		if (wrOsc) begin
			oscCtl_d = hwdata[7:0];
		end
		if (wrCfg) begin
			priCfg_d = hwdata[2:0]; // RL3
		end
		if (wrWake) begin
			ulpEn_d = hwdata[`PMCS_BIT_ULPEN];
			if (hwdata[`PMCS_BIT_ULPFLAG]) begin
				ulpFlag_d = 1'b0;
			end
		end
		// Set beats a same-cycle write-one clear
		if (ulpEvent) begin
			ulpFlag_d = 1'b1; // RL8
		end
	end

	// Mode machine and clock switching
	pmcs_pkg::pmcs_mode_t mode_q, mode_d;
	logic [1:0] curSrc_q, curSrc_d;
	logic [7:0] swCnt_q,  swCnt_d;
	logic       gateSel, deepSel;
	logic [1:0] reqSrc;
	logic       wakeAny;

	always_comb begin
		gateSel = oscCtl_q[`PMCS_BIT_GATE]; // RL1
		deepSel = oscCtl_q[`PMCS_BIT_DEEP];
		reqSrc  = oscCtl_q[`PMCS_SRCSEL_HI:`PMCS_SRCSEL_LO]; // RL2
		wakeAny = wakeCmd || ulpEvent;
	end

	always_comb begin
		mode_d   = mode_q;
		curSrc_d = curSrc_q;
		swCnt_d  = swCnt_q;
		case (mode_q)
			pmcs_pkg::PMCS_RUN: begin
				if (sleepCmd) begin
					// Bits as they stand before the sleep decide the target
					if (gateSel) begin // RL7
						mode_d = pmcs_pkg::PMCS_IDLE; // RL9
					end else if (deepSel) begin
						mode_d = pmcs_pkg::PMCS_DEEP; // RL9
					end else begin
						mode_d = pmcs_pkg::PMCS_SLEEP; // RL5
					end
				end
			end
			pmcs_pkg::PMCS_IDLE: begin
				if (wakeAny) begin
					mode_d = pmcs_pkg::PMCS_RUN;
				end
			end
			pmcs_pkg::PMCS_SLEEP: begin
				if (wakeAny) begin
					mode_d = pmcs_pkg::PMCS_RUN;
				end
			end
			pmcs_pkg::PMCS_DEEP: begin
				if (wakeAny) begin
					mode_d = pmcs_pkg::PMCS_RUN;
				end
			end
			default: begin
				mode_d = pmcs_pkg::PMCS_RUN;
			end
		endcase
		// Switch only to a running source, after the transition delay
		if (reqSrc == curSrc_q || !srcIsRunning(reqSrc, runSync)) begin
			swCnt_d = '0; // RL10
		end else if (swCnt_q >= 8'(SWITCH_CYC - 1)) begin
			curSrc_d = reqSrc; // RL4
			swCnt_d  = '0;
		end else begin
			swCnt_d = swCnt_q + 8'h01; // RL4
		end
	end

	// Output register values, carried together
	pmcs_pkg::pmcs_clkstate_t clkNext;
	logic                     asleep;
	always_comb begin
		asleep            = (mode_d == pmcs_pkg::PMCS_SLEEP) || (mode_d == pmcs_pkg::PMCS_DEEP);
		clkNext.cpuClk    = (mode_d == pmcs_pkg::PMCS_RUN); // RL1
		clkNext.periphClk = !asleep; // RL6
		clkNext.source    = asleep ? pmcs_pkg::PMCS_SRC_NONE : pmcs_pkg::pmcs_src_t'(curSrc_d); // RL6
		clkNext.mode      = mode_d;
	end

	// Read mux
	always_comb begin
		hrdata_d = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			case (haddr)
				`PMCS_OFF_OSCCTL:  hrdata_d = {24'h00_0000, oscCtl_q};
				`PMCS_OFF_CONFIG:  hrdata_d = {29'h0000_0000, priCfg_q};
				`PMCS_OFF_STATUS:  hrdata_d = {26'h000_0000, runSync, curSrc_q != reqSrc, mode_q};
				`PMCS_OFF_WAKECTL: hrdata_d = {30'h0000_0000, ulpFlag_q, ulpEn_q};
				default:           hrdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			apValid_q     <= 1'b0;
			apWrite_q     <= 1'b0;
			apAddr_q      <= 12'h000;
			hrdata        <= 32'h0000_0000;
			hreadyout     <= 1'b1;
			hresp         <= 1'b0;
			oscCtl_q      <= `PMCS_OSCCTL_RESET;
			priCfg_q      <= `PMCS_PRICFG_RESET;
			ulpEn_q       <= 1'b0;
			ulpFlag_q     <= 1'b0;
			wakePinPrev_q <= 1'b0;
			mode_q        <= pmcs_pkg::PMCS_RUN;
			curSrc_q      <= 2'h0;
			swCnt_q       <= 8'h00;
			cpuClkEn      <= 1'b1;
			periphClkEn   <= 1'b1;
			activeSource  <= 2'h0;
			primaryKind   <= 3'h0;
			powerMode     <= 2'h0;
			ulpWakeIrq    <= 1'b0;
		end else begin
			apValid_q     <= apValid_d;
			apWrite_q     <= apWrite_d;
			apAddr_q      <= apAddr_d;
			hrdata        <= hrdata_d;
			hreadyout     <= 1'b1;
			hresp         <= 1'b0;
			oscCtl_q      <= oscCtl_d;
			priCfg_q      <= priCfg_d;
			ulpEn_q       <= ulpEn_d;
			ulpFlag_q     <= ulpFlag_d;
			wakePinPrev_q <= wakePinPrev_d;
			mode_q        <= mode_d;
			curSrc_q      <= curSrc_d;
			swCnt_q       <= swCnt_d;
			cpuClkEn      <= clkNext.cpuClk;
			periphClkEn   <= clkNext.periphClk;
			activeSource  <= clkNext.source;
			primaryKind   <= priCfg_d; // RL3
			powerMode     <= clkNext.mode;
			ulpWakeIrq    <= ulpFlag_d;
		end
	end
endmodule
`default_nettype wire

// *** pkg/pmcs_consts.svh ***
// Purpose: Constants for the power mode and clock select block
// Assumes: 32-bit AHB-Lite register bus, 200 MHz clock
// Notes:   Offsets are byte addresses
`ifndef PMCS_CONSTS_SVH
`define PMCS_CONSTS_SVH

`define PMCS_OFF_OSCCTL     12'h000
`define PMCS_OFF_CONFIG     12'h004
`define PMCS_OFF_COMMAND    12'h008
`define PMCS_OFF_STATUS     12'h00C
`define PMCS_OFF_WAKECTL    12'h010

`define PMCS_BIT_GATE       7
`define PMCS_BIT_DEEP       3
`define PMCS_SRCSEL_HI      1
`define PMCS_SRCSEL_LO      0
`define PMCS_BIT_SLEEP      0
`define PMCS_BIT_WAKE       1
`define PMCS_BIT_ULPEN      0
`define PMCS_BIT_ULPFLAG    1

`define PMCS_OSCCTL_RESET   8'h00
`define PMCS_PRICFG_RESET   3'h0
`define PMCS_SWITCH_NS      20
`define PMCS_CLK_MHZ        200

`endif

// *** pkg/pmcs_pkg.sv ***
// Purpose: Types for the power mode and clock select block
// Assumes: Constants come from pmcs_consts.svh
// Notes:   Mode encoding is Gray along Run, Idle, Sleep, DeepSleep
`default_nettype none
package pmcs_pkg;

	typedef enum logic [1:0] {
		PMCS_RUN   = 2'h0,
		PMCS_IDLE  = 2'h1,
		PMCS_SLEEP = 2'h3,
		PMCS_DEEP  = 2'h2
	} pmcs_mode_t;

	typedef enum logic [1:0] {
		PMCS_SRC_PRIMARY   = 2'h0,
		PMCS_SRC_SECONDARY = 2'h1,
		PMCS_SRC_INTERNAL  = 2'h2,
		PMCS_SRC_NONE      = 2'h3
	} pmcs_src_t;

	typedef struct packed {
		logic       cpuClk;
		logic       periphClk;
		pmcs_src_t  source;
		pmcs_mode_t mode;
	} pmcs_clkstate_t;

endpackage
`default_nettype wire

// *** test/pmcs_tb_top.sv ***
// Purpose: Directed bench for pmcs_top
// Assumes: Zero wait state bus, pins driven on clock edges
// Notes: Fixed waits cover pin sync plus switch delay
`include "pmcs_consts.svh"
`default_nettype none
module pmcs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic	clk, rst_n, hsel, hwrite, hready, hresp, portABitZero, cpuClkEn, periphClkEn, ulpWakeIrq;
	logic [1:0]	htrans, activeSource, powerMode;
	logic [2:0]	hsize, srcRunning, primaryKind;
	logic [11:0]	haddr;
	logic [31:0]	hwdata, hrdata, rd;
	int	num_errors, n_checks;
	pmcs_top i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.srcRunning(srcRunning), .portABitZero(portABitZero), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
		.activeSource(activeSource), .primaryKind(primaryKind), .powerMode(powerMode), .ulpWakeIrq(ulpWakeIrq));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Reads the ready seen at the edge, before the edge's updates land
	task automatic waitRdy();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hready !== 1'b1 && k < 20);
		if (hready !== 1'b1) begin
			num_errors++;
			tally_and_finish();
		end
	endtask
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		waitRdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy();
		rd = hrdata;
	endtask
	task automatic sleepChk(input logic [1:0] em, input logic [1:0] es);
		bus(`PMCS_OFF_COMMAND, 1'b1, 32'h0000_0001);
		@(posedge clk);
		chk("mode", 32'(powerMode), 32'(em));
		chk("cpuClk", 32'(cpuClkEn), 32'h0000_0000);
		chk("periphClk", 32'(periphClkEn), 32'(em == 2'h1));
		chk("source", 32'(activeSource), 32'(es));
		bus(`PMCS_OFF_COMMAND, 1'b1, 32'h0000_0002);
		repeat (2) @(posedge clk);
		chk("wake", 32'(powerMode), 32'h0000_0000);
	endtask
	task automatic t_reset();
		chk("rstMode", 32'(powerMode), 32'h0000_0000);
		chk("rstCpu", 32'(cpuClkEn), 32'h0000_0001);
		bus(`PMCS_OFF_OSCCTL, 1'b0, 32'h0000_0000);
		chk("oscRst", rd, 32'h0000_0000);
		chk("hresp", 32'(hresp), 32'h0000_0000);
		bus(12'h020, 1'b1, 32'hFFFF_FFFF);
		bus(12'h020, 1'b0, 32'h0000_0000);
		chk("unmapped", rd, 32'h0000_0000);
		$display("test reset done");
	endtask
	task automatic t_modes();
		logic [7:0] cfg [3];
		cfg = '{8'h80, 8'h08, 8'h00};
		for (int i = 0; i < 3; i++) begin
			bus(`PMCS_OFF_OSCCTL, 1'b1, {24'h00_0000, cfg[i]});
			repeat (2) @(posedge clk);
			chk("noSleepYet", 32'(powerMode), 32'h0000_0000);
			// Second pass is a bare sleep with the bits left as they are
			repeat (2) sleepChk(cfg[i][7] ? 2'h1 : cfg[i][3] ? 2'h2 : 2'h3, cfg[i][7] ? 2'h0 : 2'h3);
		end
		$display("test modes done");
	endtask
	task automatic t_switch();
		bus(`PMCS_OFF_OSCCTL, 1'b1, 32'h0000_0001);
		repeat (12) @(posedge clk);
		chk("switch", 32'(activeSource), 32'h0000_0001);
		bus(`PMCS_OFF_OSCCTL, 1'b1, 32'h0000_0002);
		repeat (12) @(posedge clk);
		chk("held", 32'(activeSource), 32'h0000_0001);
		// Status: sources 0 and 1 running, switch pending, Run
		bus(`PMCS_OFF_STATUS, 1'b0, 32'h0000_0000);
		chk("pending", rd, 32'h0000_001C);
		srcRunning <= 3'h7;
		repeat (12) @(posedge clk);
		chk("late", 32'(activeSource), 32'h0000_0002);
		bus(`PMCS_OFF_OSCCTL, 1'b1, 32'h0000_0082);
		sleepChk(2'h1, 2'h2);
		bus(`PMCS_OFF_OSCCTL, 1'b1, 32'h0000_0000);
		repeat (12) @(posedge clk);
		$display("test switch done");
	endtask
	task automatic t_kind();
		bus(`PMCS_OFF_CONFIG, 1'b1, 32'h0000_0005);
		repeat (3) @(posedge clk);
		chk("kind", 32'(primaryKind), 32'h0000_0005);
		chk("srcKept", 32'(activeSource), 32'h0000_0000);
		$display("test kind done");
	endtask
	task automatic t_ulp();
		bus(`PMCS_OFF_WAKECTL, 1'b1, 32'h0000_0001);
		bus(`PMCS_OFF_COMMAND, 1'b1, 32'h0000_0001);
		@(posedge clk);
		chk("asleep", 32'(powerMode), 32'h0000_0003);
		portABitZero <= 1'b0;
		repeat (10) @(posedge clk);
		chk("ulpIrq", 32'(ulpWakeIrq), 32'h0000_0001);
		chk("ulpRun", 32'(powerMode), 32'h0000_0000);
		bus(`PMCS_OFF_WAKECTL, 1'b1, 32'h0000_0002);
		repeat (3) @(posedge clk);
		chk("ulpClr", 32'(ulpWakeIrq), 32'h0000_0000);
		$display("test ulp done");
	endtask
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		srcRunning = 3'h3;
		portABitZero = 1'b1;
		rst_n = 1'b0;
		num_errors = 0;
		n_checks = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_modes();
		t_switch();
		t_kind();
		t_ulp();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// *** test/pmcs_top_asserts.sv ***
// Purpose: Port assertions for pmcs_top
// Assumes: Zero wait state bus
// Notes: Shadows control writes; select changes during a pending switch are not modelled
`include "pmcs_consts.svh"
`default_nettype none
module pmcs_top_asserts (
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic	hsel,
	input wire logic [11:0]	haddr,
	input wire logic [1:0]	htrans,
	input wire logic	hwrite,
	input wire logic	hready,
	input wire logic [31:0]	hwdata,
	input wire logic [2:0]	srcRunning,
	input wire logic	portABitZero,
	input wire logic	cpuClkEn,
	input wire logic	periphClkEn,
	input wire logic [1:0]	activeSource,
	input wire logic [2:0]	primaryKind,
	input wire logic [1:0]	powerMode,
	input wire logic	ulpWakeIrq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0]	addrQ;
	logic	wrQ;
	logic [7:0]	oscQ;
	logic	ulpEnQ;
	logic	cmdPh;
	assign cmdPh = wrQ && addrQ == `PMCS_OFF_COMMAND;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addrQ <= 12'h000;
			wrQ <= 1'b0;
			oscQ <= 8'h00;
			ulpEnQ <= 1'b0;
		end else begin
			addrQ <= haddr;
			wrQ <= hsel && hready && htrans[1] && hwrite;
			if (wrQ && addrQ == `PMCS_OFF_OSCCTL) oscQ <= hwdata[7:0];
			if (wrQ && addrQ == `PMCS_OFF_WAKECTL) ulpEnQ <= hwdata[0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_RUN_CLK: assert property (powerMode == 2'h0 |-> cpuClkEn && periphClkEn)
		else $error("run mode gates wrong");
	AST_SLEEP_ENTRY: assert property (cmdPh && hwdata[0] && !hwdata[1] && powerMode == 2'h0 |=>
		powerMode == (oscQ[7] ? 2'h1 : oscQ[3] ? 2'h2 : 2'h3)) else $error("wrong mode after sleep");
	AST_STAY_RUN: assert property (powerMode == 2'h0 && !(cmdPh && hwdata[0]) |=> powerMode == 2'h0)
		else $error("left run without sleep");
	AST_IDLE_CLK: assert property (powerMode == 2'h1 |-> !cpuClkEn && periphClkEn && activeSource != 2'h3)
		else $error("idle gates wrong");
	AST_SLEEP_NOCLK: assert property (powerMode[1] |-> !cpuClkEn && !periphClkEn && activeSource == 2'h3)
		else $error("sleep still clocked");
	AST_SWITCH_TARGET: assert property (powerMode == 2'h0 && $past(powerMode) == 2'h0 && $changed(activeSource)
		|-> activeSource == oscQ[1:0]) else $error("switched to unselected source");
	AST_STOPPED_HOLD: assert property ((powerMode == 2'h0 && oscQ[1:0] != 2'h3 && !srcRunning[oscQ[1:0]]) [*6]
		|=> $stable(activeSource)) else $error("switched to stopped source");
	AST_KIND: assert property (wrQ && addrQ == `PMCS_OFF_CONFIG |-> ##2 primaryKind == $past(hwdata[2:0], 2))
		else $error("primary kind not taken");
	AST_ULP_WAKE: assert property (ulpEnQ && $fell(portABitZero) |-> ##[2:8] ulpWakeIrq)
		else $error("no wake on falling pin");
	cover property (powerMode == 2'h1);
	cover property (powerMode == 2'h2);
	cover property (ulpWakeIrq);
endmodule
bind pmcs_top pmcs_top_asserts i_chk (.*);
`default_nettype wire
